/* File: fpa_pkg.sv */
// Package for the floating-point absolute-value and add-immediate block.
// Assumes one core clock domain and a host pipeline issuing one word pair per cycle.
package fpa_pkg;
    localparam int          FPA_NREG        = 8;
    localparam int          FPA_RSEL_W      = 3;
    localparam logic [15:0] FPA_ABS_LOW_OP  = 16'hE695;
    localparam logic [15:0] FPA_ABS_HIGH_MK = 16'hFFC0;
    localparam logic [9:0]  FPA_ADD_LOW_OP  = 10'h3A2;
    localparam int          FPA_LOW_OP_POS  = 6;
    localparam int          FPA_DST_POS     = 0;
    localparam int          FPA_SRC_POS     = 3;
    localparam int          FPA_SIGN_POS    = 31;
    localparam int          FPA_EXP_LSB     = 23;
    localparam int          FPA_EXP_MSB     = 30;
    localparam logic [7:0]  FPA_EXP_MAX     = 8'hFF;
    localparam logic [31:0] FPA_REG_RST     = 32'h0000_0000;
    localparam int          FPA_ADD_LAT     = 2;

    typedef struct packed {
        logic [15:0] low_word;
        logic [15:0] high_word;
    } fpa_instr_t;

    typedef struct packed {
        logic test_flag;
        logic integer_zero_flag;
        logic integer_negative_flag;
        logic zero_flag;
        logic negative_flag;
        logic latched_underflow_flag;
        logic latched_overflow_flag;
    } fpa_flags_t;

    typedef struct packed {
        logic [31:0] sum;
        logic        underflow;
        logic        overflow;
    } fpa_sum_t;
endpackage

/* File: fpa_adder.sv */
// Registered single-precision adder stage, flushing denormals to zero.
// Assumes operands are held stable only in the cycle i_valid is high.
`timescale 1ns/100ps
module fpa_adder (
    input  wire logic              i_core_clk,
    input  wire logic              i_rst,
    input  wire logic              i_valid,
    input  wire logic [31:0]       i_a,
    input  wire logic [31:0]       i_b,
    output fpa_pkg::fpa_sum_t      o_res
);
    logic [7:0]  ea, eb, el, es, ediff;
    logic [24:0] ma, mb, ml, ms, ms_sh;
    logic [26:0] msum;
    logic        sl, ss, swap, eff_sub;
    logic [9:0]  eres;
    logic [4:0]  lz;
    logic [26:0] mnorm;
    fpa_pkg::fpa_sum_t res_next, res_reg;

    assign ea      = i_a[fpa_pkg::FPA_EXP_MSB:fpa_pkg::FPA_EXP_LSB];
    assign eb      = i_b[fpa_pkg::FPA_EXP_MSB:fpa_pkg::FPA_EXP_LSB];
    assign ma      = (ea == 8'h00) ? 25'h0000000 : {2'b01, i_a[22:0]};
    assign mb      = (eb == 8'h00) ? 25'h0000000 : {2'b01, i_b[22:0]};
    assign swap    = {eb, i_b[22:0]} > {ea, i_a[22:0]};
    assign el      = swap ? eb : ea;
    assign es      = swap ? ea : eb;
    assign ml      = swap ? mb : ma;
    assign ms      = swap ? ma : mb;
    assign sl      = swap ? i_b[31] : i_a[31];
    assign ss      = swap ? i_a[31] : i_b[31];
    assign eff_sub = sl ^ ss;
    assign ediff   = el - es;
    assign ms_sh   = (ediff > 8'd24) ? 25'h0000000 : (ms >> ediff);
    assign msum    = eff_sub ? {2'b00, ml} - {2'b00, ms_sh} : {2'b00, ml} + {2'b00, ms_sh};

    // The hidden bit sits at position 23; a carry out of the addition lands at 24.
    always_comb begin
        lz = 5'd0;
        for (int k = 0; k < 24; k++) begin
            if (msum[k]) begin
                lz = 5'(23 - k);
            end
        end
    end

    always_comb begin
        res_next = '0;
        if (msum[24]) begin
            eres  = {2'b00, el} + 10'd1;
            mnorm = msum >> 1;
        end else begin
            eres  = {2'b00, el} - {5'b00000, lz};
            mnorm = msum << lz;
        end
        if (msum == 27'h0 || el == 8'h00) begin
            res_next.sum = 32'h0000_0000;
        end else if (eres[9] || eres == 10'd0) begin
            res_next.sum       = {sl, 31'h0000_0000};
            res_next.underflow = 1'b1;
        end else if (eres >= {2'b00, fpa_pkg::FPA_EXP_MAX}) begin
            // Saturate to the largest finite magnitude rather than a NaN pattern.
            res_next.sum      = {sl, fpa_pkg::FPA_EXP_MAX - 8'h01, 23'h7FFFFF};
            res_next.overflow = 1'b1;
        end else begin
            res_next.sum = {sl, eres[7:0], mnorm[22:0]};
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            res_reg <= '0;
        else if (i_valid)
            res_reg <= res_next;
    end

    assign o_res = res_reg;
endmodule

/* File: fpa_core.sv */
// Execution core for absolute value and add-with-upper-half-immediate operations.
// Assumes the host issues one instruction per cycle and honours the add delay slot.
// Behaviour
// - Absolute value decoded from fixed low word and zero high word bits 15:6; high word holds source and destination.
// - Absolute value writes source with sign cleared, other bits unchanged.
// - Absolute value clears negative flag; zero flag set iff exponent zero.
// - Absolute value result usable by the very next instruction.
// - Add forms operand from immediate upper half, lower half zero, adds source.
// - Add sets latched underflow or overflow flags; other flags unchanged.
// - Add takes two cycles; destination written after one delay slot.
`timescale 1ns/100ps
module fpa_core #(
    parameter int NREG = fpa_pkg::FPA_NREG
) (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_issue,
    input  fpa_pkg::fpa_instr_t        i_instr,
    input  wire logic                  i_flag_load,
    input  fpa_pkg::fpa_flags_t        i_flag_value,
    input  wire logic [2:0]            i_rd_sel,
    output logic [31:0]                o_rd_data,
    output fpa_pkg::fpa_flags_t        o_float_status_register,
    output logic                       o_illegal,
    output logic                       o_add_busy
);
    typedef enum logic [0:0] {
        FPA_IDLE = 1'b0,
        FPA_ADD  = 1'b1
    } fpa_state_t;

    logic [31:0]         fp_reg [NREG];
    fpa_pkg::fpa_flags_t flags_reg, flags_next;
    fpa_state_t          state_reg, state_next;
    logic [2:0]          add_dst_reg;
    logic [31:0]         rd_reg;
    logic                illegal_reg;

    wire [2:0]  dest_fp_register = i_instr.high_word[fpa_pkg::FPA_DST_POS +: 3];
    wire [2:0]  src_sel          = i_instr.high_word[fpa_pkg::FPA_SRC_POS +: 3];
    wire [15:0] upper_half_immediate = {i_instr.low_word[5:0], i_instr.high_word[15:6]};
    wire        fp_absolute_value_op = i_issue
                    && i_instr.low_word == fpa_pkg::FPA_ABS_LOW_OP
                    && (i_instr.high_word & fpa_pkg::FPA_ABS_HIGH_MK) == 16'h0000;
    wire        fp_add_op = i_issue
                    && i_instr.low_word[15:fpa_pkg::FPA_LOW_OP_POS] == fpa_pkg::FPA_ADD_LOW_OP;
    wire [31:0] src_val  = fp_reg[src_sel];
    wire [31:0] abs_val  = {1'b0, src_val[30:0]};
    wire [31:0] imm_op   = {upper_half_immediate, 16'h0000};
    wire        add_done = state_reg == FPA_ADD;
    fpa_pkg::fpa_sum_t add_res;

    // Zero test of the exponent field, shared by the flag update and its checker.
    function automatic logic exp_is_zero(input logic [31:0] v);
        return v[fpa_pkg::FPA_EXP_MSB:fpa_pkg::FPA_EXP_LSB] == 8'h00;
    endfunction

    fpa_adder u_adder (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_valid    (fp_add_op),
        .i_a        (src_val),
        .i_b        (imm_op),
        .o_res      (add_res)
    );

    assign state_next = fp_add_op ? FPA_ADD : FPA_IDLE;

    always_comb begin
        flags_next = flags_reg;
        if (i_flag_load)
            flags_next = i_flag_value;
        if (fp_absolute_value_op) begin
            flags_next.negative_flag = 1'b0;
            flags_next.zero_flag     = exp_is_zero(src_val);
        end
        if (add_done) begin
            flags_next.latched_underflow_flag = flags_next.latched_underflow_flag
                                                | add_res.underflow;
            flags_next.latched_overflow_flag  = flags_next.latched_overflow_flag
                                                | add_res.overflow;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_reg   <= FPA_IDLE;
            flags_reg   <= '0;
            add_dst_reg <= 3'd0;
            rd_reg      <= fpa_pkg::FPA_REG_RST;
            illegal_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            flags_reg   <= flags_next;
            rd_reg      <= fp_reg[i_rd_sel];
            illegal_reg <= i_issue && !fp_absolute_value_op && !fp_add_op;
            if (fp_add_op)
                add_dst_reg <= dest_fp_register;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            for (int r = 0; r < NREG; r++)
                fp_reg[r] <= fpa_pkg::FPA_REG_RST;
        end else begin
            if (fp_absolute_value_op)
                fp_reg[dest_fp_register] <= abs_val;
            if (add_done)
                fp_reg[add_dst_reg] <= add_res.sum;
        end
    end

    assign o_rd_data               = rd_reg;
    assign o_float_status_register = flags_reg;
    assign o_illegal               = illegal_reg;
    assign o_add_busy              = add_done;

    fpa_pkg::fpa_flags_t flags_prev;
    always_ff @(posedge i_core_clk) flags_prev <= flags_reg;

    sequence add_issue_s;
        fp_add_op;
    endsequence

    abs_value_write_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        fp_absolute_value_op && !(add_done && add_dst_reg == dest_fp_register)
        |=> fp_reg[$past(dest_fp_register)] == {1'b0, $past(src_val[30:0])})
        else $error("Absolute value result wrong.");
    abs_neg_clear_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        fp_absolute_value_op |=> !flags_reg.negative_flag)
        else $error("Negative flag not cleared.");
    abs_zero_flag_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        fp_absolute_value_op |=> flags_reg.zero_flag == exp_is_zero($past(src_val)))
        else $error("Zero flag wrong after absolute value.");
    add_latency_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        add_issue_s |=> add_done ##1 fp_reg[$past(add_dst_reg)] == $past(add_res.sum))
        else $error("Add result not written after delay slot.");
    add_flags_keep_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        add_done && !i_flag_load && !fp_absolute_value_op |=>
        flags_reg.zero_flag == flags_prev.zero_flag
        && flags_reg.negative_flag == flags_prev.negative_flag
        && flags_reg.test_flag == flags_prev.test_flag)
        else $error("Add disturbed unrelated flags.");
    add_ovf_latch_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        add_done && add_res.overflow |=> flags_reg.latched_overflow_flag)
        else $error("Overflow not latched.");
    add_unf_latch_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        add_done && add_res.underflow |=> flags_reg.latched_underflow_flag)
        else $error("Underflow not latched.");
    add_imm_form_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        fp_add_op |-> imm_op == {i_instr.low_word[5:0], i_instr.high_word[15:6], 16'h0000})
        else $error("Immediate operand formed wrongly.");

    sequence abs_issue_s;
        fp_absolute_value_op;
    endsequence

    sequence odd_issue_s;
        i_issue && !fp_absolute_value_op && !fp_add_op;
    endsequence

    // Two absolute values in a row, the second reading what the first wrote.
    sequence abs_chain_s;
        fp_absolute_value_op ##1 fp_absolute_value_op && !$past(add_done)
            && src_sel == $past(dest_fp_register);
    endsequence

    // The delay slot is visible on the busy output for exactly one cycle.
    add_busy_set_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        add_issue_s |=> o_add_busy)
        else $error("Busy not raised in the add delay slot.");

    add_busy_clear_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        add_issue_s ##1 !fp_add_op |=> !o_add_busy)
        else $error("Busy held after the add delay slot.");

    add_dst_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        fp_add_op && !(add_done && add_dst_reg == dest_fp_register)
        |=> fp_reg[add_dst_reg] == $past(fp_reg[dest_fp_register]))
        else $error("Add destination changed before the slot passed.");

    abs_chain_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        abs_chain_s |-> src_val == {1'b0, $past(src_val[30:0])})
        else $error("Back-to-back absolute value read a stale source.");

    abs_flags_keep_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        abs_issue_s ##0 (!i_flag_load && !add_done) |=>
        flags_reg.test_flag == flags_prev.test_flag
        && flags_reg.integer_zero_flag == flags_prev.integer_zero_flag
        && flags_reg.integer_negative_flag == flags_prev.integer_negative_flag
        && flags_reg.latched_underflow_flag == flags_prev.latched_underflow_flag
        && flags_reg.latched_overflow_flag == flags_prev.latched_overflow_flag)
        else $error("Absolute value disturbed unrelated flags.");

    // Anything that decodes as neither operation is reported and otherwise ignored.
    odd_pulse_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        odd_issue_s |=> o_illegal)
        else $error("Unknown instruction not flagged.");

    odd_quiet_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !i_issue |=> !o_illegal)
        else $error("Illegal flag raised without an issue.");

    odd_no_flags_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        odd_issue_s ##0 (!i_flag_load && !add_done) |=> flags_reg == flags_prev)
        else $error("Unknown instruction changed the flags.");

    rd_data_lat_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        1'b1 |=> o_rd_data == $past(fp_reg[i_rd_sel]))
        else $error("Read data is not the selected register.");

    flag_load_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_flag_load && !fp_absolute_value_op && !add_done
        |=> flags_reg == $past(i_flag_value))
        else $error("Status load did not take.");
endmodule

/* File: fpa_host.sv */
// Host pipeline model that issues instruction word pairs to the core.
// Assumes the bench calls its tasks and the core clock runs freely.
`timescale 1ns/100ps
module fpa_host (
    input  wire logic           i_core_clk,
    output logic                o_issue,
    output fpa_pkg::fpa_instr_t o_instr
);
    initial begin
        o_issue = 1'b0;
        o_instr = 32'h0000_0000;
    end
    // A word pair stands until the next call; calls in a row issue back to back.
    task automatic send(input logic [31:0] w);
        @(negedge i_core_clk);
        o_issue = 1'b1;
        o_instr = w;
    endtask
    // An idle slot withdraws issue and scrambles the words so stale data never decodes.
    task automatic idle();
        @(negedge i_core_clk);
        o_issue = 1'b0;
        o_instr = ~o_instr;
    endtask
    task automatic abs_op(input logic [2:0] s, input logic [2:0] d);
        send({fpa_pkg::FPA_ABS_LOW_OP, 10'h000, s, d});
    endtask
    task automatic add_op(input logic [15:0] imm, input logic [2:0] s, input logic [2:0] d);
        send({fpa_pkg::FPA_ADD_LOW_OP, imm, s, d});
    endtask
endmodule

/* File: fpa_core_tb.sv */
// Self-checking bench for the absolute-value and add-immediate core.
// Assumes the host model issues all instructions and registers reset to zero.
`timescale 1ns/100ps
module fpa_core_tb;
    logic                i_core_clk   = 1'b0;
    logic                i_rst        = 1'b1;
    logic                i_flag_load  = 1'b0;
    fpa_pkg::fpa_flags_t i_flag_value = 7'h00;
    logic [2:0]          i_rd_sel     = 3'h0;
    logic                issue;
    fpa_pkg::fpa_instr_t instr;
    logic [31:0]         o_rd_data;
    fpa_pkg::fpa_flags_t o_float_status_register;
    logic                o_illegal;
    logic                o_add_busy;
    int                  err_count    = 0;
    int                  tests_run    = 0;

    always #2.5 i_core_clk = ~i_core_clk;

    fpa_host host (.i_core_clk(i_core_clk), .o_issue(issue), .o_instr(instr));
    fpa_core uut (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_issue(issue), .i_instr(instr),
        .i_flag_load(i_flag_load), .i_flag_value(i_flag_value), .i_rd_sel(i_rd_sel),
        .o_rd_data(o_rd_data), .o_float_status_register(o_float_status_register),
        .o_illegal(o_illegal), .o_add_busy(o_add_busy)
    );

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [2:0] r, input logic [31:0] exp);
        @(negedge i_core_clk);
        i_rd_sel = r;
        repeat (2) @(negedge i_core_clk);
        chk(o_rd_data, exp);
    endtask
    task automatic load_flags(input logic [6:0] v);
        @(negedge i_core_clk);
        i_flag_load  = 1'b1;
        i_flag_value = v;
        @(negedge i_core_clk);
        i_flag_load  = 1'b0;
    endtask
    task automatic t_add_slot();
        host.add_op(16'hC000, 3'h0, 3'h1);
        host.abs_op(3'h0, 3'h2);
        chk({31'h0, o_add_busy}, 32'h1);
        i_rd_sel = 3'h1;
        host.idle();
        chk(o_rd_data, 32'h0000_0000);
        chk({31'h0, o_add_busy}, 32'h0);
        repeat (2) @(negedge i_core_clk);
        chk(o_rd_data, 32'hC000_0000);
        chk({25'h0, o_float_status_register}, 32'h08);
        $display("test add_slot done");
    endtask
    task automatic t_abs_flags();
        load_flags(7'h7F);
        host.abs_op(3'h1, 3'h3);
        host.abs_op(3'h3, 3'h4);
        host.idle();
        rd(3'h3, 32'h4000_0000);
        rd(3'h4, 32'h4000_0000);
        chk({25'h0, o_float_status_register}, 32'h73);
        host.abs_op(3'h0, 3'h7);
        host.idle();
        rd(3'h7, 32'h0000_0000);
        chk({25'h0, o_float_status_register}, 32'h7B);
        $display("test abs_flags done");
    endtask
    task automatic add_gap(input logic [15:0] imm, input logic [2:0] s, input logic [2:0] d);
        host.add_op(imm, s, d);
        repeat (3) host.idle();
    endtask
    task automatic t_limits();
        load_flags(7'h00);
        add_gap(16'h7F00, 3'h0, 3'h5);
        rd(3'h5, 32'h7F00_0000);
        add_gap(16'h7F00, 3'h5, 3'h6);
        chk({25'h0, o_float_status_register}, 32'h01);
        rd(3'h6, 32'h7F7F_FFFF);
        add_gap(16'h0081, 3'h0, 3'h7);
        rd(3'h7, 32'h0081_0000);
        add_gap(16'h8080, 3'h7, 3'h7);
        chk({25'h0, o_float_status_register}, 32'h03);
        rd(3'h7, 32'h0000_0000);
        $display("test limits done");
    endtask
    task automatic t_illegal();
        host.send(32'h0000_0000);
        host.idle();
        chk({31'h0, o_illegal}, 32'h1);
        @(negedge i_core_clk);
        chk({31'h0, o_illegal}, 32'h0);
        host.send(32'hE695_0041);
        host.idle();
        chk({31'h0, o_illegal}, 32'h1);
        rd(3'h1, 32'hC000_0000);
        chk({25'h0, o_float_status_register}, 32'h03);
        $display("test illegal done");
    endtask

    initial begin
        repeat (3) @(negedge i_core_clk);
        i_rst = 1'b0;
        chk({25'h0, o_float_status_register}, 32'h0);
        t_add_slot();
        t_abs_flags();
        t_limits();
        t_illegal();
        close_out();
    end
    // The tests need well under a thousand cycles; this cuts a hang short.
    initial begin
        #20000;
        err_count++;
        close_out();
    end
endmodule
